// file: tb/board_strap_model.sv
`timescale 1ns/1ps
`default_nettype none

module board_strap_model (
  // Pin drive from the hub, and the memory disable strap
  input wire logic data_oe,
  input wire logic data_out,
  input wire logic mem_disable,
  // Board strap level
  input wire logic gang_strap,
  // Resolved shared pin
  output logic data_in
);
  // shared pin: hub drive, else pull-down or static strap
  // With memory enabled and the hub not driving, the pull-down wins
  always_comb begin
    if (data_oe) begin
      data_in = data_out;
    end else if (!mem_disable) begin
      data_in = 1'b0;
    end else begin
      data_in = gang_strap;
    end
  end
endmodule : board_strap_model

`default_nettype wire

// file: tb/tb_hub_strap_and_pullup_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "hub_strap_params.svh"

module tb_hub_strap_and_pullup_ctrl;
  localparam int unsigned DLY = 20;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pss, emd, gs, pu_o, pu_oe, ck_o, ck_oe;
  logic d_in, d_o, d_oe, self_p, gang, def_ids;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] req, oc_n, pwr;
  int failures, n_checks, cycles;

  // Short delay keeps the run brief
  hub_strap_and_pullup_ctrl #(.PULLUP_DELAY_CYCLES(DLY)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .power_source_select(pss), .external_memory_disable(emd),
    .upstream_pullup_control_out(pu_o), .upstream_pullup_control_oe(pu_oe),
    .serial_memory_clock_out(ck_o), .serial_memory_clock_oe(ck_oe),
    .serial_memory_data_or_gang_select_in(d_in), .serial_memory_data_or_gang_select_out(d_o),
    .serial_memory_data_or_gang_select_oe(d_oe), .self_powered(self_p), .gang_mode(gang),
    .use_default_ids(def_ids), .port_power_request(req), .overcurrent_n(oc_n),
    .port_power_on(pwr));

  board_strap_model partner (.data_oe(d_oe), .data_out(d_o), .mem_disable(emd),
    .gang_strap(gs), .data_in(d_in));

  // Core clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard, well above the planned run
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // Float after reset, then driven high
  task automatic test_reset_pullup();
    cyc(2);
    check(pu_oe, 1'b0);
    cyc(DLY + 8);
    check({pu_oe, pu_o}, 2'b11);
    $display("done: reset pull-up");
  endtask : test_reset_pullup

  // Select change restarts the float interval
  task automatic test_select_change();
    @(posedge aclk);
    pss <= ~pss;
    cyc(3);
    check(pu_oe, 1'b0);
    check(self_p, pss);
    cyc(DLY - 6);
    check(pu_oe, 1'b0);
    cyc(11);
    check({pu_oe, pu_o}, 2'b11);
    axi_read(`OFS_STATUS, rd, rs);
    check(rd[1:0], {1'b1, pss});
    $display("done: select change");
  endtask : test_select_change

  // Memory enabled, then disabled while the register still asks for drive
  task automatic test_memory();
    @(posedge aclk);
    emd <= 1'b0;
    cyc(3);
    check({ck_oe, def_ids}, 2'b10);
    axi_write(`OFS_MEMCTL, 32'h7, rs);
    check(rs, `RESP_OKAY);
    cyc(3);
    check({ck_o, d_oe, d_o}, 3'b111);
    axi_read(`OFS_STATUS, rd, rs);
    check(rd[4:3], 2'b11);
    @(posedge aclk);
    emd <= 1'b1;
    cyc(3);
    check({ck_oe, d_oe, def_ids}, 3'b001);
    check(gang, gs);
    axi_read(`OFS_MEMCTL, rd, rs);
    check(rd, 32'h7);
    axi_write(`OFS_MEMCTL, 32'h0, rs);
    $display("done: memory pins");
  endtask : test_memory

  // Strap set only while the pin is not a selector
  task automatic test_overcurrent(input logic g);
    @(posedge aclk);
    emd <= 1'b0;
    gs <= g;
    req <= 3'h7;
    cyc(2);
    emd <= 1'b1;
    cyc(3);
    check({gang, pwr}, {g, 3'h7});
    oc_n <= 3'h6;
    cyc(2);
    oc_n <= 3'h7;
    cyc(2);
    check(pwr, g ? 3'h0 : 3'h6);
    axi_read(`OFS_TRIP, rd, rs);
    check(rd[10:8], g ? 3'h7 : 3'h1);
    axi_write(`OFS_TRIP, 32'h700, rs);
    cyc(3);
    check(pwr, 3'h7);
    $display("done: overcurrent");
  endtask : test_overcurrent

  // Unmapped address answers with a decode error
  task automatic test_unmapped();
    axi_write(8'h0c, 32'hffffffff, rs);
    check(rs, `RESP_DECERR);
    axi_read(8'h0c, rd, rs);
    check({rd, rs}, {32'h0, `RESP_DECERR});
    $display("done: unmapped");
  endtask : test_unmapped

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pss, gs} = '0;
    {awaddr, araddr, wdata, wstrb, req} = '0;
    emd = 1'b1;
    oc_n = 3'h7;
    {failures, n_checks, cycles} = '0;
    cyc(3);
    aresetn <= 1'b1;
    test_reset_pullup();
    test_select_change();
    test_select_change();
    test_memory();
    test_overcurrent(1'b0);
    test_overcurrent(1'b1);
    test_unmapped();
    report_and_stop();
  end
endmodule : tb_hub_strap_and_pullup_ctrl

`default_nettype wire

// file: verilog/hub_strap_and_pullup_ctrl.sv
// Operation
// R1: Power select low means bus-powered downstream ports, high means self-powered.
// R2: Board holds the power select level fixed during operation.
// R3: After reset or power select change, pull-up floats until 15 ms counted.
// R4: After expiry, pull-up driven high until next reset or select change.
// R5: Memory select high disables the serial memory interface and its clock pin.
// R6: Memory select low makes the serial clock a three-state output.
// R7: Memory select high samples the shared data pin as gang-mode select.
// R8: Memory select low uses the shared pin as bidirectional serial data.
// R9: Board keeps the gang select level static during operation.
// R10: Memory select high reports built-in default vendor and product identifiers.
// R11: Ganged overcurrent removes all port power; per-port removes only that port.
// R12: Delay counter runs on core clock, restarts on reset and select edges.
`timescale 1ns/1ps
`default_nettype none
`include "hub_strap_params.svh"

module hub_strap_and_pullup_ctrl
  import hub_strap_pkg::*;
#(
  parameter int unsigned PORTS = 3,
  parameter int unsigned ADDR_WIDTH = 8,
  parameter int unsigned PULLUP_DELAY_CYCLES = `PULLUP_DELAY_MS * `CORE_CLK_KHZ
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus, write side
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Register bus, read side
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Straps
  input wire logic power_source_select,
  input wire logic external_memory_disable,
  // Upstream pull-up control
  output logic upstream_pullup_control_out,
  output logic upstream_pullup_control_oe,
  // Serial memory pins
  output logic serial_memory_clock_out,
  output logic serial_memory_clock_oe,
  input wire logic serial_memory_data_or_gang_select_in,
  output logic serial_memory_data_or_gang_select_out,
  output logic serial_memory_data_or_gang_select_oe,
  // Decoded configuration
  output logic self_powered,
  output logic gang_mode,
  output logic use_default_ids,
  // Downstream port power
  input wire logic [PORTS-1:0] port_power_request,
  input wire logic [PORTS-1:0] overcurrent_n,
  output logic [PORTS-1:0] port_power_on
);

  localparam int unsigned CNT_W = $clog2(PULLUP_DELAY_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(PULLUP_DELAY_CYCLES);

  // Refuse shapes the status word, the decoder or the delay counter cannot hold
  if (PORTS < 1 || PORTS > 32 - `ST_TRIP_LSB) begin : g_bad_ports
    $error("PORTS does not fit the trip field of the status word");
  end
  if (ADDR_WIDTH < 8) begin : g_bad_addr
    $error("ADDR_WIDTH must be at least 8");
  end
  if (PULLUP_DELAY_CYCLES < 1) begin : g_bad_delay
    $error("PULLUP_DELAY_CYCLES must be at least 1");
  end

  // Whole state; width depends on PORTS so it lives here
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pss_prev;
    logic [CNT_W-1:0] pull_cnt;
    logic pullup_oe;
    logic [`MC_WIDTH-1:0] memctl;
    logic clk_out;
    logic clk_oe;
    logic data_out;
    logic data_oe;
    logic data_seen;
    logic self_powered;
    logic gang_mode;
    logic ids_default;
    logic [PORTS-1:0] tripped;
    logic [PORTS-1:0] port_on;
  } state_type;

  state_type s_q;
  state_type s_d;

  // Word-aligned decode; low two address bits are ignored
  function automatic reg_sel_type decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [7:0] ofs;
    ofs = {addr[7:2], 2'h0};
    if (ADDR_WIDTH > 8 && |(addr >> 8)) return sel_none;
    case (ofs)
      `OFS_STATUS: return sel_status;
      `OFS_MEMCTL: return sel_memctl;
      `OFS_TRIP: return sel_trip;
      default: return sel_none;
    endcase
  endfunction : decode

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction : merge

  // Next-state logic
  always_comb begin
    logic have_aw;
    logic have_w;
    logic [ADDR_WIDTH-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [31:0] word;
    logic [31:0] wmerge;
    logic [PORTS-1:0] clr;
    logic [PORTS-1:0] trip_set;
    have_aw = s_q.aw_held || (awvalid && s_q.awready);
    have_w = s_q.w_held || (wvalid && s_q.wready);
    wa = s_q.aw_held ? s_q.aw_addr : awaddr;
    wd = s_q.w_held ? s_q.w_data : wdata;
    ws = s_q.w_held ? s_q.w_strb : wstrb;
    word = '0;
    wmerge = '0;
    clr = '0;
    trip_set = '0;
    s_d = s_q;

    // Write channel; address and data may arrive in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid && bready) s_d.bvalid = 1'b0;
    if (have_aw && have_w) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `RESP_OKAY;
      unique case (decode(wa))
        sel_memctl: begin
          wmerge = merge(32'(s_q.memctl), wd, ws);
          s_d.memctl = wmerge[`MC_WIDTH-1:0];
        end
        sel_trip: begin
          wmerge = merge(32'h0, wd, ws);
          clr = wmerge[`ST_TRIP_LSB +: PORTS];
        end
        sel_status: s_d.bresp = `RESP_OKAY;
        sel_none: s_d.bresp = `RESP_DECERR;
      endcase
    end
    // One write outstanding: no new address or data while a response waits
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready = !s_d.w_held && !s_d.bvalid;

    // Read channel
    if (s_q.rvalid && rready) s_d.rvalid = 1'b0;
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `RESP_OKAY;
      unique case (decode(araddr))
        sel_status: begin
          word[`ST_SELF_POWERED] = s_q.self_powered;
          word[`ST_PULLUP] = s_q.pullup_oe;
          word[`ST_GANG] = s_q.gang_mode;
          word[`ST_MEM_EN] = !s_q.ids_default;
          word[`ST_DATA_IN] = s_q.data_seen;
          word[`ST_TRIP_LSB +: PORTS] = s_q.tripped;
        end
        sel_memctl: word[`MC_WIDTH-1:0] = s_q.memctl;
        sel_trip: word[`ST_TRIP_LSB +: PORTS] = s_q.tripped;
        sel_none: s_d.rresp = `RESP_DECERR;
      endcase
      s_d.rdata = word;
    end
    s_d.arready = !s_d.rvalid;

    // R1 power mode decode
    s_d.self_powered = power_source_select;
    // R12 restart on select edge
    s_d.pss_prev = power_source_select;
    if (power_source_select != s_q.pss_prev) begin
      s_d.pull_cnt = '0;
    end else if (s_q.pull_cnt != CNT_MAX) begin
      s_d.pull_cnt = CNT_W'(s_q.pull_cnt + 1'b1);
    end
    // R3 R4 float until expiry, then drive high
    s_d.pullup_oe = (s_d.pull_cnt == CNT_MAX);

    // R5 R6 serial clock three-state
    s_d.clk_oe = !external_memory_disable;
    s_d.clk_out = !external_memory_disable && s_q.memctl[`MC_CLK];
    // R8 shared pin as serial data
    s_d.data_oe = !external_memory_disable && s_q.memctl[`MC_DRIVE];
    s_d.data_out = s_q.memctl[`MC_DATA];
    s_d.data_seen = serial_memory_data_or_gang_select_in;
    // R7 gang select sampled while memory is off
    if (external_memory_disable) s_d.gang_mode = serial_memory_data_or_gang_select_in;
    // R10 default identifiers
    s_d.ids_default = external_memory_disable;

    // R11 ganged trips every port; set wins over software clear
    if (s_q.gang_mode && |(~overcurrent_n)) trip_set = '1;
    else trip_set = ~overcurrent_n;
    s_d.tripped = (s_q.tripped & ~clr) | trip_set;
    s_d.port_on = port_power_request & ~s_d.tripped;
  end

  // State register; power and memory select copies loaded at reset, so they show no false edge or stale flag; gang_mode resets to 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.memctl <= `MC_RESET;
      s_q.pss_prev <= power_source_select;
      s_q.self_powered <= power_source_select;
      s_q.ids_default <= external_memory_disable;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign upstream_pullup_control_out = s_q.pullup_oe;
  assign upstream_pullup_control_oe = s_q.pullup_oe;
  assign serial_memory_clock_out = s_q.clk_out;
  assign serial_memory_clock_oe = s_q.clk_oe;
  assign serial_memory_data_or_gang_select_out = s_q.data_out;
  assign serial_memory_data_or_gang_select_oe = s_q.data_oe;
  assign self_powered = s_q.self_powered;
  assign gang_mode = s_q.gang_mode;
  assign use_default_ids = s_q.ids_default;
  assign port_power_on = s_q.port_on;

  // Checks, all in the core clock domain
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_select_edge;
    $changed(power_source_select);
  endsequence

  sequence s_count_last;
    (s_q.pull_cnt == CNT_MAX - 1'b1) && !$changed(power_source_select);
  endsequence

  a_power_mode: assert property (1'b1 |=> self_powered == $past(power_source_select)) // R1
    else $error("self powered flag does not follow select");
  a_pullup_float: assert property (s_select_edge |=> !upstream_pullup_control_oe ##0 // R3
    s_q.pull_cnt == '0)
    else $error("pull-up not released on select change");
  a_pullup_expire: assert property (s_count_last |=> upstream_pullup_control_oe) // R3
    else $error("pull-up not driven at count expiry");
  a_pullup_hold: assert property (upstream_pullup_control_oe && !$changed(power_source_select) // R4
    |=> upstream_pullup_control_oe && upstream_pullup_control_out)
    else $error("pull-up dropped without cause");
  a_pullup_early: assert property (upstream_pullup_control_oe |-> s_q.pull_cnt == CNT_MAX) // R12
    else $error("pull-up driven before counter expiry");
  a_clock_off: assert property (external_memory_disable |=> !serial_memory_clock_oe) // R5
    else $error("serial clock driven while memory disabled");
  a_clock_on: assert property (!external_memory_disable |=> serial_memory_clock_oe) // R6
    else $error("serial clock not driven while memory enabled");
  a_gang_sample: assert property (external_memory_disable // R7
    |=> gang_mode == $past(serial_memory_data_or_gang_select_in))
    else $error("gang select not sampled");
  a_data_release: assert property (external_memory_disable // R8
    |=> !serial_memory_data_or_gang_select_oe)
    else $error("shared pin driven while used as gang select");
  a_default_ids: assert property (1'b1 |=> use_default_ids == $past(external_memory_disable)) // R10
    else $error("default identifier flag wrong");
  a_gang_trip: assert property (gang_mode && |(~overcurrent_n) |=> port_power_on == '0) // R11
    else $error("ganged overcurrent left a port powered");
  a_port_trip: assert property (!gang_mode && !overcurrent_n[0] |=> !port_power_on[0]) // R11
    else $error("per-port overcurrent left port powered");

endmodule : hub_strap_and_pullup_ctrl
`default_nettype wire

// file: verilog/hub_strap_params.svh
`ifndef HUB_STRAP_PARAMS_SVH
`define HUB_STRAP_PARAMS_SVH

// Core clock and pull-up release time
`define CORE_CLK_KHZ 40000
`define PULLUP_DELAY_MS 15

// Register byte offsets
`define OFS_STATUS 8'h00
`define OFS_MEMCTL 8'h04
`define OFS_TRIP 8'h08

// Status register fields
`define ST_SELF_POWERED 0
`define ST_PULLUP 1
`define ST_GANG 2
`define ST_MEM_EN 3
`define ST_DATA_IN 4
`define ST_TRIP_LSB 8

// Serial memory control fields
`define MC_CLK 0
`define MC_DATA 1
`define MC_DRIVE 2
`define MC_WIDTH 3
`define MC_RESET 3'h0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// file: verilog/hub_strap_pkg.sv
package hub_strap_pkg;

  // Register selected by a bus address
  typedef enum logic [1:0] {
    sel_status,
    sel_memctl,
    sel_trip,
    sel_none
  } reg_sel_type;

endpackage : hub_strap_pkg
